//--- src/pac_params.svh
// Offsets, field positions, reset values and timing for the amplifier control block
`ifndef PAC_PARAMS_SVH
`define PAC_PARAMS_SVH
// Register indices; byte address is four times the index
`define PAC_IDX_CFG 12'h3aa
`define PAC_IDX_CTRL 12'h3b0
`define PAC_IDX_AUX 12'h3b1
`define PAC_IDX_BIAS 12'h3b2
`define PAC_IDX_DAC 12'h3b3
`define PAC_IDX_STAT 12'h3b4
// Config register fields
`define PAC_CFG_MODE_LSB 0
`define PAC_CFG_SRC_BIT 3
`define PAC_CFG_PWR_LSB 4
// Control register fields
`define PAC_CTRL_RDN_BIT 0
`define PAC_CTRL_AUTO_BIT 1
`define PAC_CTRL_RATE_LSB 4
// Aux power-down register fields
`define PAC_AUX_EXTEN_BIT 0
// Bias register fields
`define PAC_BIAS_CTRL_LSB 0
`define PAC_BIAS_BRIDGE_LSB 8
// Reset values
`define PAC_CFG_RST 8'hf0
`define PAC_CTRL_RST 8'h00
`define PAC_AUX_RST 8'h00
`define PAC_BIAS_RST 13'h0000
`define PAC_DAC_RST 5'h00
// Ramp step base time in tenths of a nanosecond, clock period likewise
`define PAC_STEP_BASE_TNS 24
`define PAC_CLK_PERIOD_TNS 1000
`endif

//--- src/pac_pkg.sv
// Types for the amplifier control block
package pac_pkg;
  typedef enum logic [1:0] {
    PAC_OFF = 2'b00,
    PAC_UP = 2'b01,
    PAC_ON = 2'b10,
    PAC_DOWN = 2'b11
  } pac_ramp_t;
  typedef enum logic [2:0] {
    PAC_PIN_UNUSED = 3'b000,
    PAC_PIN_SOURCE = 3'b001,
    PAC_PIN_SINK = 3'b010,
    PAC_PIN_SERVO_POS = 3'b011,
    PAC_PIN_SERVO_NEG = 3'b100,
    PAC_PIN_RESERVED = 3'b111
  } pac_pin_t;
endpackage

//--- src/pac_ramp_timer.sv
// Ramp step pacing: one tick each 2^rate x 2.4 ns of elapsed time for rate 6 and up, one tick per clock for rates 0 to 5
`timescale 1ns/1ns
`include "pac_params.svh"
module pac_ramp_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [3:0] rate,
  output logic tick
);
  logic [20:0] acc;
  logic [20:0] next_acc;
  logic next_tick;
  logic [20:0] step;

  always_comb begin
    step = 21'(`PAC_STEP_BASE_TNS) << rate;
    next_acc = acc;
    next_tick = 1'b0;
    if (!run) begin
      next_acc = 21'h0;
    end else if (acc >= step) begin
      // At most one code per clock; fast rates saturate here
      next_tick = 1'b1;
      next_acc = acc - step + 21'(`PAC_CLK_PERIOD_TNS);
      if (next_acc > 21'(`PAC_CLK_PERIOD_TNS) + step) begin
        next_acc = 21'(`PAC_CLK_PERIOD_TNS) + step;
      end
    end else begin
      next_acc = acc + 21'(`PAC_CLK_PERIOD_TNS);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= 21'h0;
      tick <= 1'b0;
    end else begin
      acc <= next_acc;
      tick <= next_tick;
    end
  end
endmodule

//--- src/pac_top.sv
// Transmit amplifier ramp control and external amplifier interface
`timescale 1ns/1ns
`include "pac_params.svh"
module pac_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_cmd,
  input wire logic tx_state,
  input wire logic packet_mode,
  input wire logic pkt_done,
  output logic [3:0] amp_level,
  output logic amp_on,
  output logic tx_go,
  output logic pkt_sent,
  output logic ext_en,
  output logic supply_close,
  output pac_pkg::pac_pin_t bias_pin_func,
  output logic bias_src_int,
  output logic [4:0] bias_dac,
  output logic [5:0] amp_bias_ctrl,
  output logic [4:0] bridge_bias
);
  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] cfg;
  logic [7:0] ctrl;
  logic [7:0] aux;
  logic [12:0] bias;
  logic [4:0] dac;
  logic [7:0] next_cfg;
  logic [7:0] next_ctrl;
  logic [7:0] next_aux;
  logic [12:0] next_bias;
  logic [4:0] next_dac;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_en;
  logic [11:0] idx;
  logic hit;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////////
  // Ramp state
  pac_pkg::pac_ramp_t rstate;
  pac_pkg::pac_ramp_t next_rstate;
  logic [3:0] next_amp_level;
  logic next_amp_on;
  logic next_tx_go;
  logic next_pkt_sent;
  logic sent_pend;
  logic next_sent_pend;
  logic tx_prev;
  logic tick;
  logic exit_ev;
  logic [3:0] code;

  ////////////////////////////////////////////////////////////////////////////////
  // External interface state
  logic next_ext_en;
  logic next_supply_close;
  pac_pkg::pac_pin_t next_bias_pin_func;
  logic next_bias_src_int;
  logic [4:0] next_bias_dac;

  function automatic logic [11:0] word_index(input logic [13:0] a);
    word_index = a[13:2];
  endfunction

  function automatic logic is_mapped(input logic [11:0] i);
    is_mapped = (i == `PAC_IDX_CFG) || (i == `PAC_IDX_CTRL) || (i == `PAC_IDX_AUX) ||
                (i == `PAC_IDX_BIAS) || (i == `PAC_IDX_DAC) || (i == `PAC_IDX_STAT);
  endfunction

  assign idx = word_index(paddr);
  assign hit = is_mapped(idx);
  assign wr_en = psel && penable && pready && pwrite && hit;
  assign code = cfg[`PAC_CFG_PWR_LSB +: 4];
  assign exit_ev = (!tx_state && tx_prev) || pkt_done;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, answer registered in the setup cycle
  always_comb begin
    rd_val = 32'h0;
    case (idx)
      `PAC_IDX_CFG: rd_val = {24'h0, cfg};
      `PAC_IDX_CTRL: rd_val = {24'h0, ctrl};
      `PAC_IDX_AUX: rd_val = {24'h0, aux};
      `PAC_IDX_BIAS: rd_val = {19'h0, bias};
      `PAC_IDX_DAC: rd_val = {27'h0, dac};
      `PAC_IDX_STAT: rd_val = {20'h0, amp_level, 1'b0, ext_en, sent_pend, tx_go,
                               amp_on, 1'b0, rstate};
      default: rd_val = 32'h0;
    endcase
    next_pready = psel && !penable && !pready;
    next_prdata = (psel && !penable && !pwrite) ? rd_val : prdata;
    next_pslverr = psel && !penable && !hit;
    next_cfg = cfg;
    next_ctrl = ctrl;
    next_aux = aux;
    next_bias = bias;
    next_dac = dac;
    if (wr_en) begin
      case (idx)
        `PAC_IDX_CFG: next_cfg = pwdata[7:0];
        `PAC_IDX_CTRL: next_ctrl = pwdata[7:0];
        `PAC_IDX_AUX: next_aux = pwdata[7:0];
        `PAC_IDX_BIAS: next_bias = pwdata[12:0];
        `PAC_IDX_DAC: next_dac = pwdata[4:0];
        default: next_cfg = cfg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= `PAC_CFG_RST;
      ctrl <= `PAC_CTRL_RST;
      aux <= `PAC_AUX_RST;
      bias <= `PAC_BIAS_RST;
      dac <= `PAC_DAC_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      ctrl <= next_ctrl;
      aux <= next_aux;
      bias <= next_bias;
      dac <= next_dac;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ramp pacing
  pac_ramp_timer u_timer (
    .clk(clk),
    .rst(rst),
    .run(rstate == pac_pkg::PAC_UP || rstate == pac_pkg::PAC_DOWN),
    .rate(ctrl[`PAC_CTRL_RATE_LSB +: 4]),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Ramp controller; one code per tick gives a linear-in-dB profile
  always_comb begin
    next_rstate = rstate;
    next_amp_level = amp_level;
    next_amp_on = amp_on;
    next_tx_go = 1'b0;
    next_pkt_sent = 1'b0;
    next_sent_pend = sent_pend || (pkt_done && packet_mode);
    case (rstate)
      pac_pkg::PAC_OFF: begin
        next_amp_level = 4'h0;
        next_amp_on = 1'b0;
        if (sent_pend) begin
          next_pkt_sent = 1'b1;
          next_sent_pend = pkt_done && packet_mode;
        end else if (tx_state && !tx_prev) begin
          next_rstate = pac_pkg::PAC_UP;
          next_amp_on = 1'b1;
        end
      end
      pac_pkg::PAC_UP: begin
        if (exit_ev) begin
          next_rstate = pac_pkg::PAC_OFF;
        end else if (amp_level >= code) begin
          next_rstate = pac_pkg::PAC_ON;
          next_tx_go = 1'b1;
        end else if (tick) begin
          next_amp_level = amp_level + 4'h1;
        end
      end
      pac_pkg::PAC_ON: begin
        next_tx_go = 1'b1;
        next_amp_level = code;
        if (exit_ev) begin
          next_tx_go = 1'b0;
          if (ctrl[`PAC_CTRL_RDN_BIT]) begin
            next_rstate = pac_pkg::PAC_DOWN;
          end else begin
            next_rstate = pac_pkg::PAC_OFF;
            next_amp_level = 4'h0;
            next_amp_on = 1'b0;
          end
        end
      end
      pac_pkg::PAC_DOWN: begin
        if (amp_level == 4'h0) begin
          next_rstate = pac_pkg::PAC_OFF;
          next_amp_on = 1'b0;
        end else if (tick) begin
          next_amp_level = amp_level - 4'h1;
        end
      end
      default: begin
        next_rstate = pac_pkg::PAC_OFF;
      end
    endcase
    // Immediate cut leaves no level behind
    if (rstate == pac_pkg::PAC_UP && exit_ev) begin
      next_amp_level = 4'h0;
      next_amp_on = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rstate <= pac_pkg::PAC_OFF;
      amp_level <= 4'h0;
      amp_on <= 1'b0;
      tx_go <= 1'b0;
      pkt_sent <= 1'b0;
      sent_pend <= 1'b0;
      tx_prev <= 1'b0;
    end else begin
      rstate <= next_rstate;
      amp_level <= next_amp_level;
      amp_on <= next_amp_on;
      tx_go <= next_tx_go;
      pkt_sent <= next_pkt_sent;
      sent_pend <= next_sent_pend;
      tx_prev <= tx_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // External amplifier interface
  always_comb begin
    if (ctrl[`PAC_CTRL_AUTO_BIT]) begin
      next_ext_en = tx_cmd || tx_state;
    end else begin
      next_ext_en = aux[`PAC_AUX_EXTEN_BIT];
    end
    next_bias_src_int = cfg[`PAC_CFG_SRC_BIT];
    next_bias_dac = dac;
    next_supply_close = 1'b0;
    next_bias_pin_func = pac_pkg::PAC_PIN_UNUSED;
    if (next_ext_en) begin
      case (cfg[`PAC_CFG_MODE_LSB +: 3])
        3'h0: next_supply_close = 1'b1;
        3'h1: begin
          next_supply_close = 1'b1;
          next_bias_pin_func = pac_pkg::PAC_PIN_SOURCE;
        end
        3'h2: begin
          next_supply_close = 1'b1;
          next_bias_pin_func = pac_pkg::PAC_PIN_SINK;
        end
        3'h3: next_bias_pin_func = pac_pkg::PAC_PIN_SOURCE;
        3'h4: next_bias_pin_func = pac_pkg::PAC_PIN_SINK;
        3'h5: begin
          next_supply_close = 1'b1;
          next_bias_pin_func = pac_pkg::PAC_PIN_SERVO_POS;
        end
        3'h6: begin
          next_supply_close = 1'b1;
          next_bias_pin_func = pac_pkg::PAC_PIN_SERVO_NEG;
        end
        default: next_bias_pin_func = pac_pkg::PAC_PIN_RESERVED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_en <= 1'b0;
      supply_close <= 1'b0;
      bias_pin_func <= pac_pkg::PAC_PIN_UNUSED;
      bias_src_int <= 1'b0;
      bias_dac <= 5'h00;
      amp_bias_ctrl <= 6'h00;
      bridge_bias <= 5'h00;
    end else begin
      ext_en <= next_ext_en;
      supply_close <= next_supply_close;
      bias_pin_func <= next_bias_pin_func;
      bias_src_int <= next_bias_src_int;
      bias_dac <= next_bias_dac;
      amp_bias_ctrl <= bias[`PAC_BIAS_CTRL_LSB +: 6];
      bridge_bias <= bias[`PAC_BIAS_BRIDGE_LSB +: 5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_ramp_start_min: assert property (@(posedge clk) disable iff (rst)
    (rstate == pac_pkg::PAC_OFF && !sent_pend && tx_state && !tx_prev)
      |=> (rstate == pac_pkg::PAC_UP && amp_level == 4'h0))
    else $error("ramp did not start from minimum");
  chk_go_after_ramp: assert property (@(posedge clk) disable iff (rst)
    $rose(tx_go) |-> $past(rstate) == pac_pkg::PAC_UP && amp_level == code)
    else $error("packet released before ramp done");
  chk_cut_at_once: assert property (@(posedge clk) disable iff (rst)
    (rstate == pac_pkg::PAC_ON && exit_ev && !ctrl[`PAC_CTRL_RDN_BIT])
      |=> (!amp_on && amp_level == 4'h0 && !tx_go))
    else $error("amplifier not cut on exit");
  chk_ramp_down_path: assert property (@(posedge clk) disable iff (rst)
    (rstate == pac_pkg::PAC_ON && exit_ev && ctrl[`PAC_CTRL_RDN_BIT])
      |=> (rstate == pac_pkg::PAC_DOWN && amp_on))
    else $error("ramp down not entered");
  chk_level_step_one: assert property (@(posedge clk) disable iff (rst)
    (rstate == pac_pkg::PAC_UP && $past(rstate) == pac_pkg::PAC_UP)
      |-> (amp_level - $past(amp_level)) <= 4'h1)
    else $error("ramp step larger than one code");
  chk_step_pace: assert property (@(posedge clk) disable iff (rst)
    (rstate == pac_pkg::PAC_UP && !exit_ev && !tick && amp_level < code)
      |=> $stable(amp_level))
    else $error("level moved without a step tick");
  chk_host_enable: assert property (@(posedge clk) disable iff (rst)
    !ctrl[`PAC_CTRL_AUTO_BIT] |=> ext_en == $past(aux[`PAC_AUX_EXTEN_BIT]))
    else $error("external enable not under host control");
  chk_auto_enable: assert property (@(posedge clk) disable iff (rst)
    (ctrl[`PAC_CTRL_AUTO_BIT] && tx_state) |=> ext_en)
    else $error("external enable missing in transmit");
  chk_switch_open: assert property (@(posedge clk) disable iff (rst)
    !ext_en |-> (!supply_close && bias_pin_func == pac_pkg::PAC_PIN_UNUSED))
    else $error("switch closed while disabled");
  chk_modes_open: assert property (@(posedge clk) disable iff (rst)
    (ext_en && $past(cfg[2:0]) inside {3'h3, 3'h4} && $stable(cfg)) |-> !supply_close)
    else $error("switch closed in open mode");
  chk_sent_after_off: assert property (@(posedge clk) disable iff (rst)
    pkt_sent |-> (!amp_on && $past(rstate) == pac_pkg::PAC_OFF))
    else $error("packet sent raised with amplifier on");
  cov_ramp_up: cover property (@(posedge clk) disable iff (rst) $rose(tx_go));
  cov_ramp_down: cover property (@(posedge clk) disable iff (rst)
    rstate == pac_pkg::PAC_DOWN ##1 rstate == pac_pkg::PAC_OFF);
  cov_sent: cover property (@(posedge clk) disable iff (rst) pkt_sent);
  cov_servo: cover property (@(posedge clk) disable iff (rst)
    bias_pin_func == pac_pkg::PAC_PIN_SERVO_NEG);
endmodule

//--- dv/pac_ext_amp_model.sv
// Behavioural model of the external amplifier stage on the supply and bias pins
`timescale 1ns/1ns
module pac_ext_amp_model (
  input wire logic supply_close,
  input wire pac_pkg::pac_pin_t bias_pin_func,
  input wire logic [4:0] bias_dac,
  output logic fet_powered,
  output logic [4:0] fet_current
);
  always_comb begin
    fet_powered = supply_close;
    fet_current = 5'h00;
    // Servo pulls drain current onto the reference, either polarity
    if (supply_close && (bias_pin_func == pac_pkg::PAC_PIN_SERVO_POS ||
        bias_pin_func == pac_pkg::PAC_PIN_SERVO_NEG)) begin
      fet_current = bias_dac;
    end
  end
endmodule

//--- dv/pac_top_tb.sv
// Self-checking bench for the transmit amplifier control block
`timescale 1ns/1ns
`include "pac_params.svh"
module pac_top_tb;
  typedef struct packed {
    logic [2:0] mode;
    logic en;
    logic src;
    logic close;
    pac_pkg::pac_pin_t func;
  } pac_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic tx_cmd = 1'b0;
  logic tx_state = 1'b0;
  logic packet_mode = 1'b1;
  logic pkt_done = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] amp_level;
  logic amp_on;
  logic tx_go;
  logic pkt_sent;
  logic ext_en;
  logic supply_close;
  pac_pkg::pac_pin_t bias_pin_func;
  logic bias_src_int;
  logic [4:0] bias_dac;
  logic [5:0] amp_bias_ctrl;
  logic [4:0] bridge_bias;
  logic fet_powered;
  logic [4:0] fet_current;
  logic [31:0] rd;
  logic err;
  int err_count = 0;
  int n_tests = 0;
  int n;
  pac_row_t rows [8];
  always #50 clk = ~clk;
  pac_top u_pac_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_cmd(tx_cmd), .tx_state(tx_state), .packet_mode(packet_mode), .pkt_done(pkt_done),
    .amp_level(amp_level), .amp_on(amp_on), .tx_go(tx_go), .pkt_sent(pkt_sent),
    .ext_en(ext_en), .supply_close(supply_close), .bias_pin_func(bias_pin_func),
    .bias_src_int(bias_src_int), .bias_dac(bias_dac), .amp_bias_ctrl(amp_bias_ctrl),
    .bridge_bias(bridge_bias));
  pac_ext_amp_model u_pac_ext_amp_model (.supply_close(supply_close),
    .bias_pin_func(bias_pin_func), .bias_dac(bias_dac), .fet_powered(fet_powered),
    .fet_current(fet_current));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, rd, err);
  endtask
  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000, rd, err);
    chk(rd, exp);
  endtask
  // Enter transmit, follow the ramp, return cycles until the packet may start
  task automatic go_tx(input logic [3:0] code, output int cnt);
    logic [3:0] last;
    @(posedge clk);
    tx_state <= 1'b1;
    cyc(2);
    chk({31'h0, amp_on}, 32'h1);
    chk({28'h0, amp_level}, 32'h0);
    chk({31'h0, tx_go}, 32'h0);
    last = 4'h0;
    cnt = 0;
    while (tx_go !== 1'b1 && cnt < 200) begin
      cyc(1);
      cnt++;
      chk({31'h0, amp_level >= last}, 32'h1);
      last = amp_level;
    end
    chk({28'h0, amp_level}, {28'h0, code});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    // No row selects mode 7
    rows[0] = '{3'h0, 1'h1, 1'h0, 1'h1, pac_pkg::PAC_PIN_UNUSED};
    rows[1] = '{3'h1, 1'h1, 1'h1, 1'h1, pac_pkg::PAC_PIN_SOURCE};
    rows[2] = '{3'h2, 1'h1, 1'h0, 1'h1, pac_pkg::PAC_PIN_SINK};
    rows[3] = '{3'h3, 1'h1, 1'h1, 1'h0, pac_pkg::PAC_PIN_SOURCE};
    rows[4] = '{3'h4, 1'h1, 1'h0, 1'h0, pac_pkg::PAC_PIN_SINK};
    rows[5] = '{3'h5, 1'h1, 1'h1, 1'h1, pac_pkg::PAC_PIN_SERVO_POS};
    rows[6] = '{3'h6, 1'h1, 1'h0, 1'h1, pac_pkg::PAC_PIN_SERVO_NEG};
    rows[7] = '{3'h5, 1'h0, 1'h1, 1'h0, pac_pkg::PAC_PIN_UNUSED};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`PAC_IDX_CFG, {24'h0, `PAC_CFG_RST});
    rd_chk(`PAC_IDX_CTRL, {24'h0, `PAC_CTRL_RST});
    rd_chk(`PAC_IDX_AUX, {24'h0, `PAC_AUX_RST});
    rd_chk(`PAC_IDX_BIAS, {19'h0, `PAC_BIAS_RST});
    rd_chk(`PAC_IDX_DAC, {27'h0, `PAC_DAC_RST});
    rd_chk(12'h100, 32'h00000000);
    chk({31'h0, err}, 32'h1);
    // High-power bias settings and full-scale DAC code
    wr(`PAC_IDX_BIAS, 32'h0000153f);
    wr(`PAC_IDX_DAC, 32'h0000001f);
    cyc(2);
    chk({26'h0, amp_bias_ctrl}, 32'h3f);
    chk({27'h0, bridge_bias}, 32'h15);
    chk({27'h0, bias_dac}, 32'h1f);
    rd_chk(`PAC_IDX_BIAS, 32'h0000153f);
    for (int i = 0; i < 8; i++) begin
      wr(`PAC_IDX_CFG, {24'h0, 4'h5, rows[i].src, rows[i].mode});
      wr(`PAC_IDX_AUX, {31'h0, rows[i].en});
      cyc(3);
      chk({31'h0, ext_en}, {31'h0, rows[i].en});
      chk({31'h0, supply_close}, {31'h0, rows[i].close});
      chk({29'h0, bias_pin_func}, {29'h0, rows[i].func});
      chk({31'h0, bias_src_int}, {31'h0, rows[i].src});
      chk({31'h0, fet_powered}, {31'h0, rows[i].close});
      chk({27'h0, fet_current},
          (rows[i].close && rows[i].mode >= 3'h5) ? 32'h1f : 32'h0);
    end
    // Slow ramp: 2^8 x 2.4 ns x 5 is about 31 cycles, then packet end
    wr(`PAC_IDX_CFG, 32'h00000050);
    wr(`PAC_IDX_CTRL, 32'h00000080);
    go_tx(4'h5, n);
    chk({31'h0, n >= 27 && n <= 36}, 32'h1);
    @(posedge clk);
    pkt_done <= 1'b1;
    @(posedge clk);
    pkt_done <= 1'b0;
    cyc(1);
    chk({31'h0, amp_on}, 32'h0);
    chk({31'h0, pkt_sent}, 32'h0);
    cyc(1);
    chk({31'h0, pkt_sent}, 32'h1);
    cyc(1);
    chk({31'h0, pkt_sent}, 32'h0);
    @(posedge clk);
    tx_state <= 1'b0;
    // Fast ramp, then cut at once on leaving transmit
    wr(`PAC_IDX_CTRL, 32'h00000000);
    cyc(4);
    go_tx(4'h5, n);
    chk({31'h0, n >= 4 && n <= 8}, 32'h1);
    @(posedge clk);
    tx_state <= 1'b0;
    cyc(2);
    chk({31'h0, amp_on}, 32'h0);
    chk({28'h0, amp_level}, 32'h0);
    // Auto enable from the transmit command, aux enable left untouched
    wr(`PAC_IDX_CTRL, 32'h00000003);
    @(posedge clk);
    tx_cmd <= 1'b1;
    cyc(3);
    chk({31'h0, ext_en}, 32'h1);
    go_tx(4'h5, n);
    @(posedge clk);
    tx_state <= 1'b0;
    cyc(2);
    chk({31'h0, amp_on}, 32'h1);
    n = 0;
    while (amp_on !== 1'b0 && n < 50) begin
      cyc(1);
      n++;
    end
    chk({31'h0, n >= 3 && n <= 8}, 32'h1);
    chk({28'h0, amp_level}, 32'h0);
    @(posedge clk);
    tx_cmd <= 1'b0;
    cyc(3);
    chk({31'h0, ext_en}, 32'h0);
    // Non-packet mode: status while on, status writes dropped, frame end gives no pulse
    wr(`PAC_IDX_CTRL, 32'h00000000);
    packet_mode <= 1'b0;
    go_tx(4'h5, n);
    rd_chk(`PAC_IDX_STAT, 32'h0000051a);
    wr(`PAC_IDX_STAT, 32'hffffffff);
    rd_chk(`PAC_IDX_STAT, 32'h0000051a);
    @(posedge clk);
    pkt_done <= 1'b1;
    @(posedge clk);
    pkt_done <= 1'b0;
    cyc(1);
    chk({31'h0, amp_on}, 32'h0);
    cyc(1);
    chk({31'h0, pkt_sent}, 32'h0);
    // Mid-run reset with transmit dropped, so no false entry edge follows
    @(posedge clk);
    tx_state <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk({31'h0, amp_on}, 32'h0);
    chk({27'h0, bias_dac}, 32'h0);
    chk({26'h0, amp_bias_ctrl}, 32'h0);
    rd_chk(`PAC_IDX_CFG, {24'h0, `PAC_CFG_RST});
    rd_chk(`PAC_IDX_BIAS, {19'h0, `PAC_BIAS_RST});
    final_report();
  end
endmodule
